// *** rtl/event_match.sv ***
// turns one selector code into a single increment strobe
module event_match (
    // selection
    input wire logic [pmu_pkg::EV_W-1:0] sel,
    input wire logic core_active,
    // core events
    input wire pmu_pkg::core_events_t ev,
    // result
    output logic inc
);
    import pmu_pkg::*;

    logic hit;

    // each code adds at most one per cycle
    always_comb begin
        case (sel)
            EV_CLK_ACTIVE: hit = 1'b1;
            EV_IC_HIT: hit = ev.ic_hit;
            EV_IC_MISS: hit = ev.ic_miss;
            EV_INSTR_ALL: hit = ev.commit;
            EV_INSTR_16: hit = ev.commit & ev.commit_16b;
            EV_INSTR_32: hit = ev.commit & ~ev.commit_16b;
            EV_ALIGNED: hit = ev.aligned;
            EV_DECODED: hit = ev.decoded;
            EV_MUL: hit = ev.mul;
            EV_DIV: hit = ev.div;
            EV_LOAD: hit = ev.load;
            EV_STORE: hit = ev.store;
            EV_MIS_LOAD: hit = ev.mis_load;
            EV_MIS_STORE: hit = ev.mis_store;
            EV_ALU: hit = ev.alu | ev.nop;
            EV_CSR_RD: hit = ev.csr_rd;
            EV_CSR_RW: hit = ev.csr_rw;
            EV_CSR_WR0: hit = ev.csr_wr0;
            EV_EBREAK: hit = ev.ebreak;
            EV_ECALL: hit = ev.ecall;
            EV_FENCE: hit = ev.fence;
            EV_FENCE_I: hit = ev.fence_i;
            EV_MRET: hit = ev.mret;
            EV_BRANCH: hit = ev.branch;
            EV_MISPRED: hit = ev.mispredict;
            default: hit = 1'b0;
        endcase
    end

    // every listed event belongs to the active state only
    assign inc = hit & core_active;

endmodule

// *** rtl/perf_counters.sv ***
// Function
// - four 64-bit event counters, each with its own event selector.
// - besides cycle (0) and instret (2), only counters and selectors 3 to 6 actually count.
// - counters and selectors 7 to 31 read zero and ignore writes.
// - power-management halt stops every counter, cycle counter included.
// - in debug halt, counting continues only while the freeze bit is clear.
// - dma accesses during halt never advance any counter.
// - a pause instruction leaves counting enabled.
// - a read sees the value before the increment; a write overrides it.
// - inhibit register has one separate bit per counter.
// - selector writes above the highest event store the highest event.
// - selector code zero counts nothing.
// - events 1 to 25 count only while the core is active.
// - events 1-3: active cycles, cache fetch hits, cache fetch misses.
// - events 4-6: committed instructions, all, 16-bit, 32-bit.
// - events 7-8: aligned and decoded instructions.
// - events 9-15: mul, div, load, store, misaligned load/store, alu.
// - nop and wfi count as alu operations.
// - events 16-18: csr read, read/write, write with rd zero.
// - events 19-23: ebreak, ecall, fence, fence.i, mret.
// - event 24 committed branches, event 25 mispredicted branches.
// - cycle and retired-instruction counters, each individually inhibitable.
module perf_counters (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core state
    input wire logic core_active,
    input wire logic pm_halt,
    input wire logic dbg_halt,
    // core event strobes
    input wire pmu_pkg::core_events_t core_events,
    // status
    output logic counting
);
    import pmu_pkg::*;

    typedef struct packed {
        logic [NUM_EV_CNT-1:0][EV_W-1:0] sel;
        logic [31:0] inhibit;
        logic freeze;
        logic [31:0] rdata;
        logic slverr;
    } regs_t;

    regs_t state_r;
    regs_t state_nxt;

    logic [NUM_SLOTS-1:0][63:0] cnt_val;
    logic [NUM_SLOTS-1:0] cnt_inc;
    logic [NUM_SLOTS-1:0] cnt_wr_lo;
    logic [NUM_SLOTS-1:0] cnt_wr_hi;
    logic [NUM_EV_CNT-1:0] ev_inc;
    logic count_ok;
    logic wr_en;
    logic rd_setup;
    logic [4:0] cnt_idx;
    logic cnt_region;
    logic sel_region;
    logic [4:0] sel_idx;
    logic slot_hit;
    logic [2:0] slot;

    // pause does not gate anything, and dma traffic is no input here, so
    // a power-management halt, or a debug halt with the freeze bit set, leaves the counters exactly where they stopped
    assign count_ok = ~pm_halt & ~(dbg_halt & state_r.freeze);
    assign counting = count_ok;

    // zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;

    // address decode
    assign cnt_region = (paddr[11:8] == CNT_BASE[11:8]);
    assign cnt_idx = paddr[7:3];
    assign sel_region = (paddr[11:7] == SEL_BASE[11:7]);
    assign sel_idx = paddr[6:2];

    // map counter index to a storage slot; unbacked indices have none
    always_comb begin
        slot_hit = 1'b1;
        slot = 3'h0;
        if (cnt_idx == 5'(IDX_CYCLE)) begin
            slot = 3'h0;
        end else if (cnt_idx == 5'(IDX_INSTRET)) begin
            slot = 3'h1;
        end else if (cnt_idx >= 5'(IDX_EV_FIRST) && cnt_idx <= 5'(IDX_EV_LAST)) begin
            slot = 3'(cnt_idx - 5'(IDX_EV_FIRST) + 5'h2);
        end else begin
            slot_hit = 1'b0;
        end
    end

    // one selector match and one counter per event counter
    genvar g;
    generate
        for (g = 0; g < NUM_EV_CNT; g++) begin : g_ev
            event_match u_match (
                .sel(state_r.sel[g]),
                .core_active(core_active),
                .ev(core_events),
                .inc(ev_inc[g])
            );
            assign cnt_inc[g+2] = count_ok & ~state_r.inhibit[IDX_EV_FIRST+g] & ev_inc[g];
        end
        for (g = 0; g < NUM_SLOTS; g++) begin : g_cnt
            assign cnt_wr_lo[g] = wr_en & cnt_region & slot_hit & (slot == 3'(g)) & ~paddr[2];
            assign cnt_wr_hi[g] = wr_en & cnt_region & slot_hit & (slot == 3'(g)) & paddr[2];
            wrap_counter #(
                .WIDTH(64)
            ) u_cnt (
                .pclk(pclk),
                .presetn(presetn),
                .inc(cnt_inc[g]),
                .wr_lo(cnt_wr_lo[g]),
                .wr_hi(cnt_wr_hi[g]),
                .wdata(pwdata),
                .value(cnt_val[g])
            );
        end
    endgenerate

    // cycle and retired-instruction counters, each behind its own inhibit bit
    assign cnt_inc[0] = count_ok & ~state_r.inhibit[IDX_CYCLE];
    assign cnt_inc[1] = count_ok & ~state_r.inhibit[IDX_INSTRET] & core_events.commit;

    // register writes, read capture and error answer
    always_comb begin
        state_nxt = state_r;
        if (wr_en) begin
            if (sel_region) begin
                for (int i = 0; i < NUM_EV_CNT; i++) begin
                    if (sel_idx == 5'(IDX_EV_FIRST + i)) begin
                        if (pwdata > 32'(EV_MAX)) begin
                            state_nxt.sel[i] = EV_MAX;
                        end else begin
                            state_nxt.sel[i] = pwdata[EV_W-1:0];
                        end
                    end
                end
            end else if (paddr == INHIBIT_ADDR) begin
                state_nxt.inhibit = pwdata & INHIBIT_MASK;
            end else if (paddr == DBG_CTRL_ADDR) begin
                state_nxt.freeze = pwdata[DBG_FREEZE_BIT];
            end
        end
        if (rd_setup) begin
            state_nxt.rdata = 32'h0000_0000;
            state_nxt.slverr = 1'b0;
            // value sampled before this cycle's increment lands
            if (cnt_region) begin
                if (slot_hit) begin
                    state_nxt.rdata = paddr[2] ? cnt_val[slot][63:32]
                                               : cnt_val[slot][31:0];
                end
            end else if (sel_region) begin
                for (int i = 0; i < NUM_EV_CNT; i++) begin
                    if (sel_idx == 5'(IDX_EV_FIRST + i)) begin
                        state_nxt.rdata = {27'h0, state_r.sel[i]};
                    end
                end
            end else if (paddr == INHIBIT_ADDR) begin
                state_nxt.rdata = state_r.inhibit;
            end else if (paddr == DBG_CTRL_ADDR) begin
                state_nxt.rdata = {31'h0, state_r.freeze};
            end else if (paddr == STATUS_ADDR) begin
                state_nxt.rdata[ST_COUNT_OK_BIT] = count_ok;
                state_nxt.rdata[ST_PM_HALT_BIT] = pm_halt;
                state_nxt.rdata[ST_DBG_HALT_BIT] = dbg_halt;
            end else begin
                // unmapped: error answer, writes there are dropped above
                state_nxt.slverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r.sel <= {NUM_EV_CNT{SEL_RESET}};
            state_r.inhibit <= INHIBIT_RESET;
            state_r.freeze <= DBG_FREEZE_RESET;
            state_r.rdata <= 32'h0000_0000;
            state_r.slverr <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata = state_r.rdata;
    assign pslverr = state_r.slverr & psel & penable;

endmodule

// *** rtl/wrap_counter.sv ***
// 64-bit counter; a write to a half wins over the increment of that cycle
module wrap_counter #(
    parameter int unsigned WIDTH = 64
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic inc,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [31:0] wdata,
    // value
    output logic [WIDTH-1:0] value
);
    import pmu_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } cnt_state_t;

    cnt_state_t state_r;
    cnt_state_t state_nxt;

    // increment wraps to zero; a write replaces its half and drops the increment
    always_comb begin
        state_nxt = state_r;
        if (inc) begin
            state_nxt.cnt = state_r.cnt + WIDTH'(1);
        end
        if (wr_lo) begin
            state_nxt.cnt = {state_r.cnt[WIDTH-1:32], wdata};
        end else if (wr_hi) begin
            state_nxt.cnt = {wdata, state_r.cnt[31:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign value = state_r.cnt;

endmodule

// *** shared/pmu_pkg.sv ***
package pmu_pkg;

    // register map, byte addresses on a 12-bit apb address
    localparam logic [11:0] CNT_BASE = 12'h000;   // counter n: low word at n*8, high at n*8+4
    localparam logic [11:0] SEL_BASE = 12'h100;   // selector n at 0x100 + n*4
    localparam logic [11:0] INHIBIT_ADDR = 12'h180;
    localparam logic [11:0] DBG_CTRL_ADDR = 12'h184;
    localparam logic [11:0] STATUS_ADDR = 12'h188;

    // counter indices in the standard numbering
    localparam int unsigned IDX_CYCLE = 0;
    localparam int unsigned IDX_INSTRET = 2;
    localparam int unsigned IDX_EV_FIRST = 3;
    localparam int unsigned IDX_EV_LAST = 6;
    localparam int unsigned NUM_EV_CNT = 4;
    localparam int unsigned NUM_SLOTS = 6;        // cycle, instret, four event counters

    // inhibit register: bit per counter; bit 1 (timer) and 7..31 read zero
    localparam logic [31:0] INHIBIT_MASK = 32'h0000_007d;
    localparam logic [31:0] INHIBIT_RESET = 32'h0000_0000;

    // debug control: freeze bit position
    localparam int unsigned DBG_FREEZE_BIT = 0;
    localparam logic DBG_FREEZE_RESET = 1'b0;

    // status bits
    localparam int unsigned ST_COUNT_OK_BIT = 0;
    localparam int unsigned ST_PM_HALT_BIT = 1;
    localparam int unsigned ST_DBG_HALT_BIT = 2;

    // event selector encoding
    localparam int unsigned EV_W = 5;
    localparam logic [EV_W-1:0] SEL_RESET = 5'h00;
    localparam logic [EV_W-1:0] EV_NONE = 5'h00;
    localparam logic [EV_W-1:0] EV_CLK_ACTIVE = 5'h01;
    localparam logic [EV_W-1:0] EV_IC_HIT = 5'h02;
    localparam logic [EV_W-1:0] EV_IC_MISS = 5'h03;
    localparam logic [EV_W-1:0] EV_INSTR_ALL = 5'h04;
    localparam logic [EV_W-1:0] EV_INSTR_16 = 5'h05;
    localparam logic [EV_W-1:0] EV_INSTR_32 = 5'h06;
    localparam logic [EV_W-1:0] EV_ALIGNED = 5'h07;
    localparam logic [EV_W-1:0] EV_DECODED = 5'h08;
    localparam logic [EV_W-1:0] EV_MUL = 5'h09;
    localparam logic [EV_W-1:0] EV_DIV = 5'h0a;
    localparam logic [EV_W-1:0] EV_LOAD = 5'h0b;
    localparam logic [EV_W-1:0] EV_STORE = 5'h0c;
    localparam logic [EV_W-1:0] EV_MIS_LOAD = 5'h0d;
    localparam logic [EV_W-1:0] EV_MIS_STORE = 5'h0e;
    localparam logic [EV_W-1:0] EV_ALU = 5'h0f;
    localparam logic [EV_W-1:0] EV_CSR_RD = 5'h10;
    localparam logic [EV_W-1:0] EV_CSR_RW = 5'h11;
    localparam logic [EV_W-1:0] EV_CSR_WR0 = 5'h12;
    localparam logic [EV_W-1:0] EV_EBREAK = 5'h13;
    localparam logic [EV_W-1:0] EV_ECALL = 5'h14;
    localparam logic [EV_W-1:0] EV_FENCE = 5'h15;
    localparam logic [EV_W-1:0] EV_FENCE_I = 5'h16;
    localparam logic [EV_W-1:0] EV_MRET = 5'h17;
    localparam logic [EV_W-1:0] EV_BRANCH = 5'h18;
    localparam logic [EV_W-1:0] EV_MISPRED = 5'h19;
    localparam logic [EV_W-1:0] EV_MAX = EV_MISPRED;

    // one-cycle event strobes from the core
    typedef struct packed {
        logic ic_hit;
        logic ic_miss;
        logic commit;          // one instruction committed this cycle
        logic commit_16b;      // qualifies commit: 16-bit encoding
        logic aligned;
        logic decoded;
        logic mul;
        logic div;
        logic load;
        logic store;
        logic mis_load;
        logic mis_store;
        logic alu;
        logic nop;             // nop or wfi committed
        logic csr_rd;
        logic csr_rw;
        logic csr_wr0;
        logic ebreak;
        logic ecall;
        logic fence;
        logic fence_i;
        logic mret;
        logic branch;
        logic mispredict;
    } core_events_t;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// *** testbench/core_model.sv ***
module core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the bench
    input wire logic fire,
    input wire logic [4:0] code,
    input wire logic as_nop,
    // strobes into the counters
    output pmu_pkg::core_events_t ev
);
    import pmu_pkg::*;
    logic [23:0] bits;
    // one strobe per request for one cycle, so at most one unit per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits <= 24'h0;
        end else begin
            bits <= 24'h0;
            if (fire && (code == 5'h02 || code == 5'h03 || code >= 5'h10)) begin
                bits[5'h19 - code] <= 1'b1;
            end else if (fire && code >= 5'h07) begin
                bits[5'h1a - code] <= !(code == 5'h0f && as_nop);
                bits[10] <= code == 5'h0f && as_nop;
            end else if (fire && code >= 5'h04) begin
                bits[21:20] <= {1'b1, code == 5'h05};
            end
        end
    end
    assign ev = core_events_t'(bits);
endmodule

// *** testbench/perf_counters_tb.sv ***
module perf_counters_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pmu_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, counting;
    logic core_active, pm_halt, dbg_halt, fire, as_nop, err_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v, n_commit;
    logic [4:0] code, ev_c;
    core_events_t core_events;
    int error_cnt, n_tests, cyc;
    logic [11:0] dead [5] = '{12'h038, 12'h0fc, 12'h11c, 12'h17c, 12'h008};
    logic [31:0] sel_in [5] = '{32'hffff_ffff, 32'h1a, 32'h40, 32'h19, 32'h1};
    logic [31:0] sel_exp [5] = '{32'h19, 32'h19, 32'h19, 32'h19, 32'h1};

    perf_counters u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_active(core_active), .pm_halt(pm_halt),
        .dbg_halt(dbg_halt), .core_events(core_events), .counting(counting));
    core_model u_core (.pclk(pclk), .presetn(presetn), .fire(fire), .code(code),
        .as_nop(as_nop), .ev(core_events));

    always #12.5 pclk = ~pclk;

    task automatic wrap_up();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a hung handshake ends here rather than running forever
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge; hold keeps psel for back-to-back
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input bit hold);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_v = prdata;
        err_v = pslverr;
        if (!hold) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 1'b0);
        check(rd_v, exp);
    endtask

    // event strobe reaches the counters two edges after the request
    task automatic pulse(input logic [4:0] c, input logic act, input logic nop);
        fire <= 1'b1;
        code <= c;
        as_nop <= nop;
        core_active <= act;
        if (c >= 5'h04 && c <= 5'h06) n_commit++;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (2) @(posedge pclk);
        // restored one edge early so a following pulse never drives it twice in one step
        core_active <= 1'b1;
        @(posedge pclk);
    endtask

    // counter 5 on active cycles: enable edge to disable edge spans 12 edges
    task automatic measure(input logic pm, input logic dbg, input logic frz,
                           input logic [31:0] exp);
        wr(DBG_CTRL_ADDR, {31'h0, frz});
        wr(CNT_BASE + 12'h028, 32'h0);
        pm_halt <= pm;
        dbg_halt <= dbg;
        wr(INHIBIT_ADDR, 32'h0000_005d);
        rd_chk(STATUS_ADDR, {29'h0, dbg, pm, !pm && !(dbg && frz)});
        repeat (6) @(posedge pclk);
        wr(INHIBIT_ADDR, 32'h0000_007d);
        pm_halt <= 1'b0;
        dbg_halt <= 1'b0;
        rd_chk(CNT_BASE + 12'h028, exp);
    endtask

    function automatic logic [4:0] other(input logic [4:0] c);
        return (c == 5'h19) ? 5'h02 : (c == 5'h04) ? 5'h07 : c + 5'h01;
    endfunction

    initial begin
        {pclk, presetn, psel, penable, pwrite, fire, as_nop, pm_halt, dbg_halt} = '0;
        {paddr, pwdata, code, n_commit} = '0;
        core_active = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(SEL_BASE + 12'h00c, 32'h0);
        rd_chk(INHIBIT_ADDR, INHIBIT_RESET);
        wr(INHIBIT_ADDR, 32'hffff_ffff);
        rd_chk(INHIBIT_ADDR, INHIBIT_MASK);
        wr(INHIBIT_ADDR, 32'h0000_007d);
        wr(CNT_BASE, 32'h0);
        foreach (dead[i]) begin
            wr(dead[i], 32'hffff_ffff);
            rd_chk(dead[i], 32'h0);
        end
        foreach (sel_in[i]) begin
            wr(SEL_BASE + 12'h018, sel_in[i]);
            rd_chk(SEL_BASE + 12'h018, sel_exp[i]);
        end
        rd_chk(12'h200, 32'h0);
        check({31'h0, err_v}, 32'h1);
        // counter 3 follows each code from 2 to 25, counter 4 sits on code zero, instret runs too
        for (int c = 2; c <= 25; c++) begin
            ev_c = 5'(c);
            wr(SEL_BASE + 12'h00c, {27'h0, ev_c});
            wr(CNT_BASE + 12'h018, 32'h0);
            wr(INHIBIT_ADDR, 32'h0000_0061);
            pulse(ev_c, 1'b1, 1'b0);
            pulse(ev_c, 1'b0, 1'b0);
            pulse(other(ev_c), 1'b1, 1'b0);
            pulse(5'h0f, 1'b1, 1'b1);
            wr(INHIBIT_ADDR, 32'h0000_007d);
            rd_chk(CNT_BASE + 12'h018, (c == 15) ? 32'h2 : 32'h1);
        end
        rd_chk(CNT_BASE + 12'h020, 32'h0);
        rd_chk(CNT_BASE + 12'h010, n_commit);
        // one increment from all ones carries into the high word and wraps the full 64 bits
        wr(CNT_BASE + 12'h018, 32'hffff_ffff);
        wr(CNT_BASE + 12'h01c, 32'hffff_ffff);
        wr(INHIBIT_ADDR, 32'h0000_0075);
        // selector 3 still holds the mispredict code from the last loop pass
        pulse(5'h19, 1'b1, 1'b0);
        wr(INHIBIT_ADDR, 32'h0000_007d);
        rd_chk(CNT_BASE + 12'h018, 32'h0);
        rd_chk(CNT_BASE + 12'h01c, 32'h0);
        // write then read back-to-back while counter 6 runs every cycle
        wr(INHIBIT_ADDR, 32'h0000_003d);
        xfer(1'b1, CNT_BASE + 12'h030, 32'h0000_0100, 1'b1);
        xfer(1'b0, CNT_BASE + 12'h030, 32'h0, 1'b0);
        check(rd_v, 32'h0000_0100);
        wr(SEL_BASE + 12'h014, 32'h1);
        measure(1'b0, 1'b0, 1'b0, 32'd12);
        measure(1'b1, 1'b0, 1'b0, 32'd0);
        measure(1'b0, 1'b1, 1'b0, 32'd12);
        measure(1'b0, 1'b1, 1'b1, 32'd0);
        rd_chk(CNT_BASE, 32'h0);
        wrap_up();
    end
endmodule

// *** testbench/pmu_sva.sv ***
module pmu_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // core state
    input wire logic pm_halt,
    input wire logic dbg_halt,
    input wire logic counting
);
    import pmu_pkg::*;
    logic rs;
    // read setup: data is latched at this edge and shown during access
    assign rs = psel && !penable && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PM_STOP: assert property (pm_halt |-> !counting)
        else $error("counting during pm halt");
    AST_FREE_RUN: assert property (!pm_halt && !dbg_halt |-> counting)
        else $error("stopped while running");
    AST_CNT_DEAD: assert property (
        rs && paddr < 12'h100 && paddr[7:3] >= 5'h07 |=> prdata == 32'h0)
        else $error("dead counter not zero");
    AST_SEL_DEAD: assert property (
        rs && paddr >= 12'h11c && paddr < 12'h180 |=> prdata == 32'h0)
        else $error("dead selector not zero");
    AST_SEL_CLAMP: assert property (
        rs && paddr[11:7] == 5'h02 |=> prdata <= 32'h19)
        else $error("selector above top event");
    AST_INH_BITS: assert property (
        rs && paddr == INHIBIT_ADDR |=> (prdata & ~INHIBIT_MASK) == 32'h0)
        else $error("inhibit spare bit set");
    AST_STATUS: assert property (
        rs && paddr == STATUS_ADDR
        |=> prdata[2:0] == {$past(dbg_halt), $past(pm_halt), $past(counting)})
        else $error("status mismatch");
    AST_RD_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
endmodule

bind perf_counters pmu_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pm_halt(pm_halt),
    .dbg_halt(dbg_halt), .counting(counting)
);
